// File: sral_host.sv
// Host controller for the security region of a serial-bus memory.
// Assumes pulled-up open-drain lines and a command source on core_clk.
// What this block does
// - Device type 1011b and chip-select bits matching the pins select the region.
// - Two word address bytes follow; bit 15 and 10 zero, bit 11 one.
// - No current-address reads; every read carries an explicit word address.
// - Any earlier command ends with Stop before the region is addressed.
// - Word address 0800h delivers the first serial-number byte.
// - A read ends with no acknowledge after the last byte, then Stop.
// - Writes use type 1011b, matching chip-select bits, write bit zero, both address bytes.
// - Lock is a byte write with word address bits 11 to 8 equal 0110b.
// - Lock still sends the low address byte and a data byte.
// - Check-lock sends device byte, first address byte with 0110b, then Stop.
// - Check-lock never sends the second address byte nor data.
`timescale 1ns/1ps
module sral_host
  import sral_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire sral_cmd_e cmd_op,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_count,
  input wire logic [2:0] chip_select,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_nack,
  output logic rsp_refused,
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  input wire logic scl_sense,
  output logic scl_val,
  output logic scl_oe,
  input wire logic sda_sense,
  output logic sda_val,
  output logic sda_oe
);
  sral_st_e state_q, state_d;
  sral_cmd_e op_q, op_d;
  logic [7:0] addr_q, addr_d, cnt_q, cnt_d, rd_data_q, rd_data_d;
  logic [2:0] cs_q, cs_d;
  logic bsy_q, bsy_d, nack_q, nack_d, err_q, err_d;
  logic rsp_valid_q, rsp_valid_d, rd_valid_q, rd_valid_d, ready_q, ready_d;
  logic go, tx_nack, f_valid, f_ready, bdone, back_n, lockish;
  logic [7:0] tx, f_data, brx;
  sral_bop_e bop;

  sral_fifo #(
    .W(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_valid(wr_valid),
    .in_data(wr_data),
    .in_ready(wr_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_ready)
  );

  sral_bit u_bit (
    .core_clk(core_clk),
    .rstn(rstn),
    .go(go),
    .op(bop),
    .tx_byte(tx),
    .tx_nack(tx_nack),
    .scl_sense(scl_sense),
    .sda_sense(sda_sense),
    .done(bdone),
    .rx_byte(brx),
    .ack_n(back_n),
    .scl_oe(scl_oe),
    .sda_oe(sda_oe)
  );

  always_comb
  begin
    state_d = state_q;
    op_d = op_q;
    addr_d = addr_q;
    cnt_d = cnt_q;
    cs_d = cs_q;
    bsy_d = bsy_q;
    nack_d = nack_q;
    err_d = err_q;
    rd_data_d = rd_data_q;
    rsp_valid_d = 1'b0;
    rd_valid_d = 1'b0;
    bop = BIT_WR;
    tx = 8'h00;
    tx_nack = 1'b0;
    go = 1'b0;
    f_ready = 1'b0;
    lockish = (op_q == OP_LOCK) || (op_q == OP_CHECK);
    case (state_q)
      ST_IDLE:
      begin
        if (cmd_valid)
        begin
          op_d = cmd_op;
          addr_d = cmd_addr;
          cnt_d = cmd_count;
          cs_d = chip_select;
          nack_d = 1'b0;
          err_d = 1'b0;
          // Refuse writes aimed at the read-only lower page
          if (cmd_op == OP_WRITE && !cmd_addr[UPPER_BIT])
          begin
            err_d = 1'b1;
            state_d = ST_DONE;
          end
          else
            state_d = ST_START;
        end
      end
      ST_START, ST_RSTART: bop = BIT_START;
      ST_DEV: tx = sral_dev_byte(cs_q, 1'b0);
      ST_DEVR: tx = sral_dev_byte(cs_q, 1'b1);
      ST_WAHI: tx = lockish ? WA_HI_LOCK : WA_HI_REGION;
      ST_WALO: tx = (op_q == OP_LOCK) ? LOCK_DUMMY : addr_q;
      ST_WDATA: tx = (op_q == OP_LOCK) ? LOCK_DUMMY : f_data;
      ST_RDATA:
      begin
        bop = BIT_RD;
        tx_nack = cnt_q == 8'h00;
      end
      ST_STOP: bop = BIT_STOP;
      ST_DONE:
      begin
        rsp_valid_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase

    // One bus step at a time; data writes wait for the FIFO
    if (state_q != ST_IDLE && state_q != ST_DONE && !bsy_q)
    begin
      if (!(state_q == ST_WDATA && op_q == OP_WRITE) || f_valid)
      begin
        go = 1'b1;
        bsy_d = 1'b1;
        f_ready = state_q == ST_WDATA && op_q == OP_WRITE;
      end
    end

    if (bdone)
    begin
      bsy_d = 1'b0;
      case (state_q)
        ST_START: state_d = ST_DEV;
        ST_RSTART: state_d = ST_DEVR;
        ST_DEV, ST_DEVR, ST_WAHI, ST_WALO, ST_WDATA:
        begin
          if (back_n)
          begin
            nack_d = 1'b1;
            state_d = ST_STOP;
          end
          else if (state_q == ST_DEV)
            state_d = ST_WAHI;
          else if (state_q == ST_DEVR)
            state_d = ST_RDATA;
          else if (state_q == ST_WAHI)
            state_d = (op_q == OP_CHECK) ? ST_STOP : ST_WALO;
          else if (state_q == ST_WALO)
            state_d = (op_q == OP_READ) ? ST_RSTART : ST_WDATA;
          else if (op_q == OP_LOCK || cnt_q == 8'h00)
            state_d = ST_STOP;
          else
            cnt_d = cnt_q - 8'h01;
        end
        ST_RDATA:
        begin
          rd_valid_d = 1'b1;
          rd_data_d = brx;
          if (cnt_q == 8'h00)
            state_d = ST_STOP;
          else
            cnt_d = cnt_q - 8'h01;
        end
        ST_STOP: state_d = ST_DONE;
        default: state_d = state_q;
      endcase
    end
    ready_d = state_d == ST_IDLE;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_IDLE;
      op_q <= OP_READ;
      addr_q <= 8'h00;
      cnt_q <= 8'h00;
      cs_q <= 3'h0;
      bsy_q <= 1'b0;
      nack_q <= 1'b0;
      err_q <= 1'b0;
      rd_data_q <= 8'h00;
      rsp_valid_q <= 1'b0;
      rd_valid_q <= 1'b0;
      ready_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      addr_q <= addr_d;
      cnt_q <= cnt_d;
      cs_q <= cs_d;
      bsy_q <= bsy_d;
      nack_q <= nack_d;
      err_q <= err_d;
      rd_data_q <= rd_data_d;
      rsp_valid_q <= rsp_valid_d;
      rd_valid_q <= rd_valid_d;
      ready_q <= ready_d;
    end
  end

  assign cmd_ready = ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_nack = nack_q;
  assign rsp_refused = err_q;
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign scl_val = 1'b0;
  assign sda_val = 1'b0;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_check_hi_ok;
    state_q == ST_WAHI && bdone && !back_n && op_q == OP_CHECK;
  endsequence
  sequence s_lock_lo_ok;
    state_q == ST_WALO && bdone && !back_n && op_q == OP_LOCK;
  endsequence
  sequence s_last_read;
    state_q == ST_RDATA && bdone && cnt_q == 8'h00;
  endsequence

  a_dev_code: assert property (
    (go && (state_q == ST_DEV || state_q == ST_DEVR)) |->
      tx[7:4] == DEV_TYPE && tx[3:1] == cs_q && tx[0] == (state_q == ST_DEVR))
    else $error("device address byte wrong");
  a_word_hi_region: assert property (
    (go && state_q == ST_WAHI && !lockish) |-> !tx[7] && tx[3] && !tx[2])
    else $error("region word address high byte wrong");
  a_lock_code: assert property (
    (go && state_q == ST_WAHI && lockish) |-> tx[3:0] == 4'h6 && !tx[7])
    else $error("lock code missing");
  a_read_addr: assert property (
    $rose(state_q == ST_RSTART) |-> $past(state_q) == ST_WALO && op_q == OP_READ)
    else $error("read without word address");
  a_start_after_stop: assert property (
    $rose(state_q == ST_START) |-> $past(state_q) == ST_IDLE && !bsy_q)
    else $error("start not after stop");
  a_low_addr: assert property (
    (go && state_q == ST_WALO && !lockish) |-> tx == addr_q)
    else $error("low word address wrong");
  a_last_nack: assert property (
    (go && state_q == ST_RDATA) |-> tx_nack == (cnt_q == 8'h00))
    else $error("read acknowledge wrong");
  a_read_stop: assert property (
    s_last_read |=> state_q == ST_STOP && go && bop == BIT_STOP)
    else $error("no stop after last read");
  a_write_upper: assert property (
    (go && state_q == ST_WDATA && op_q == OP_WRITE) |-> addr_q[UPPER_BIT] && f_ready)
    else $error("write to lower page");
  a_lock_data: assert property (
    s_lock_lo_ok |=> state_q == ST_WDATA && go && tx == LOCK_DUMMY)
    else $error("lock data byte missing");
  a_check_stop: assert property (
    s_check_hi_ok |=> state_q == ST_STOP && go && bop == BIT_STOP)
    else $error("check-lock went past first address byte");
  a_nack_ends: assert property (
    (bdone && back_n && state_q != ST_RDATA && state_q != ST_START && state_q != ST_RSTART
      && state_q != ST_STOP) |=> state_q == ST_STOP && nack_q)
    else $error("refused byte did not end transfer");
endmodule // sral_host

// File: sral_pkg.sv
// Constants, types and helpers for the security region host controller.
// Assumes a 100 MHz core clock; shared by the controller, bit engine and FIFO.
package sral_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 1000;
  // Least quarter of a serial clock period, rounded up to whole cycles
  localparam int QTR_CYC = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QTR_W = 5;
  localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);
  localparam logic [3:0] DEV_TYPE = 4'hB;
  localparam logic [7:0] WA_HI_REGION = 8'h08;
  localparam logic [7:0] WA_HI_LOCK = 8'h06;
  localparam logic [7:0] LOCK_DUMMY = 8'h00;
  localparam int UPPER_BIT = 7;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam logic [3:0] LAST_BIT = 4'h8;

  typedef enum logic [1:0] {OP_READ = 2'h0, OP_WRITE = 2'h1, OP_LOCK = 2'h2, OP_CHECK = 2'h3} sral_cmd_e;
  typedef enum logic [1:0] {BIT_START = 2'h0, BIT_WR = 2'h1, BIT_RD = 2'h2, BIT_STOP = 2'h3} sral_bop_e;
  typedef enum logic [1:0] {E_IDLE = 2'h0, E_START = 2'h1, E_BITS = 2'h3, E_STOP = 2'h2} sral_eng_e;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_START = 4'h1, ST_DEV = 4'h3, ST_WAHI = 4'h2, ST_WALO = 4'h6, ST_WDATA = 4'h7,
    ST_RSTART = 4'h5, ST_DEVR = 4'h4, ST_RDATA = 4'hC, ST_STOP = 4'hD, ST_DONE = 4'hF
  } sral_st_e;

  function automatic logic [7:0] sral_dev_byte(input logic [2:0] cs, input logic rd);
    sral_dev_byte = {DEV_TYPE, cs, rd};
  endfunction
endpackage

// File: sral_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; in_ready comes from a flip-flop.
`timescale 1ns/1ps
module sral_fifo
  import sral_pkg::*;
#(
  parameter int W = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic rdy_q, rdy_d;
  logic push, pop;

  always_comb
  begin
    push = in_valid && rdy_q;
    pop = out_ready && (cnt_q != '0);
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    rdy_d = cnt_d < (AW+1)'(DEPTH);
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wr_q] <= in_data;
  end

  assign in_ready = rdy_q;
  assign out_valid = cnt_q != '0;
  assign out_data = mem[rd_q];
endmodule // sral_fifo

// File: sral_bit.sv
// Serial bus bit engine: Start, Stop, and nine-bit byte transfers.
// Assumes open-drain pins; enable high pulls the line low. Honours clock stretching.
`timescale 1ns/1ps
module sral_bit
  import sral_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic go,
  input wire sral_bop_e op,
  input wire logic [7:0] tx_byte,
  input wire logic tx_nack,
  input wire logic scl_sense,
  input wire logic sda_sense,
  output logic done,
  output logic [7:0] rx_byte,
  output logic ack_n,
  output logic scl_oe,
  output logic sda_oe
);
  sral_eng_e st_q, st_d;
  sral_bop_e op_q, op_d;
  logic [QTR_W-1:0] div_q, div_d;
  logic [1:0] qtr_q, qtr_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic nack_q, nack_d, done_q, done_d, ack_q, ack_d, scl_q, scl_d, sda_q, sda_d;
  logic scl1_q, scl2_q, sda1_q, sda2_q;
  logic tick, bitval;

  always_comb
  begin
    st_d = st_q;
    op_d = op_q;
    div_d = div_q;
    qtr_d = qtr_q;
    bit_d = bit_q;
    sh_d = sh_q;
    nack_d = nack_q;
    ack_d = ack_q;
    scl_d = scl_q;
    sda_d = sda_q;
    done_d = 1'b0;
    // Hold the phase while a released clock is still held low
    tick = (div_q == QTR_LAST) && !(!scl_q && !scl2_q);
    if (bit_q == LAST_BIT)
      bitval = (op_q == BIT_WR) ? 1'b1 : nack_q;
    else
      bitval = (op_q == BIT_WR) ? sh_q[7] : 1'b1;
    if (st_q == E_IDLE)
    begin
      if (go)
      begin
        st_d = (op == BIT_START) ? E_START : (op == BIT_STOP) ? E_STOP : E_BITS;
        op_d = op;
        sh_d = tx_byte;
        nack_d = tx_nack;
        div_d = '0;
        qtr_d = 2'h0;
        bit_d = 4'h0;
      end
    end
    else
    begin
      if (!(!scl_q && !scl2_q))
        div_d = (div_q == QTR_LAST) ? '0 : div_q + 1'b1;
      if (tick)
      begin
        qtr_d = qtr_q + 2'h1;
        case (st_q)
          E_START:
          begin
            case (qtr_q)
              2'h0: sda_d = 1'b0;
              2'h1: scl_d = 1'b0;
              2'h2: sda_d = 1'b1;
              default:
              begin
                scl_d = 1'b1;
                done_d = 1'b1;
                st_d = E_IDLE;
              end
            endcase
          end
          E_BITS:
          begin
            case (qtr_q)
              2'h0: sda_d = !bitval;
              2'h1: scl_d = 1'b0;
              2'h2:
              begin
                if (bit_q == LAST_BIT)
                  ack_d = sda2_q;
                else
                  sh_d = {sh_q[6:0], sda2_q};
              end
              default:
              begin
                scl_d = 1'b1;
                bit_d = bit_q + 4'h1;
                if (bit_q == LAST_BIT)
                begin
                  done_d = 1'b1;
                  st_d = E_IDLE;
                end
              end
            endcase
          end
          default:
          begin
            case (qtr_q)
              2'h0:
              begin
                scl_d = 1'b1;
                sda_d = 1'b1;
              end
              2'h1: scl_d = 1'b0;
              2'h2: sda_d = 1'b0;
              default:
              begin
                done_d = 1'b1;
                st_d = E_IDLE;
              end
            endcase
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= E_IDLE;
      op_q <= BIT_START;
      div_q <= '0;
      qtr_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      nack_q <= 1'b0;
      ack_q <= 1'b1;
      done_q <= 1'b0;
      scl_q <= 1'b0;
      sda_q <= 1'b0;
      scl1_q <= 1'b1;
      scl2_q <= 1'b1;
      sda1_q <= 1'b1;
      sda2_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      op_q <= op_d;
      div_q <= div_d;
      qtr_q <= qtr_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      nack_q <= nack_d;
      ack_q <= ack_d;
      done_q <= done_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
      scl1_q <= scl_sense;
      scl2_q <= scl1_q;
      sda1_q <= sda_sense;
      sda2_q <= sda1_q;
    end
  end

  assign done = done_q;
  assign rx_byte = sh_q;
  assign ack_n = ack_q;
  assign scl_oe = scl_q;
  assign sda_oe = sda_q;
endmodule // sral_bit

// File: sral_dev_model.sv
// Behavioural security-region memory answering on the serial bus.
// Assumes pulled-up lines whose levels the bench resolves from all enables.
`timescale 1ns/1ps
module sral_dev_model
#(
  parameter logic [2:0] PINS = 3'h5
)
(
  input wire logic scl,
  input wire logic sda,
  input wire logic wp,
  input wire logic slow,
  output logic sda_oe,
  output logic scl_oe,
  output int frame_bytes,
  output int starts
);
  logic [7:0] mem [256];
  logic [7:0] shadow [256];
  logic [7:0] sh, ptr, out;
  logic act, rd, addr_ok, is_lock, lock_armed, wrote, mack;
  logic locked = 1'b0;
  int cnt, bi;

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = (i < 128) ? 8'(i) ^ 8'h5A : 8'hFF;
    {sda_oe, scl_oe, act, addr_ok} = 4'h0;
    starts = 0;
    frame_bytes = 0;
  end

  function automatic logic accept(input logic [7:0] b);
    accept = 1'b1;
    if (bi == 0)
    begin
      accept = b[7:4] == 4'hB && b[3:1] == PINS && (!b[0] || addr_ok);
      rd = b[0];
      if (b[0])
        ptr = ptr - 8'h01;
    end
    else if (bi == 1)
    begin
      is_lock = b[3:0] == 4'h6;
      accept = !b[7] && (is_lock ? !locked : b[3:2] == 2'b10);
    end
    else if (bi == 2)
    begin
      ptr = b;
      addr_ok = !is_lock;
      accept = !is_lock || !locked;
    end
    else if (is_lock)
    begin
      lock_armed = !locked;
      accept = !locked;
    end
    else
    begin
      if (ptr[7])
        shadow[ptr] = b;
      wrote = 1'b1;
      ptr[6:0] = ptr[6:0] + 7'h01;
    end
    if (!accept)
      act = 1'b0;
  endfunction

  // Start or repeated start
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      starts++;
      shadow = mem;
      {act, rd, wrote, lock_armed, sda_oe} = 5'h10;
      cnt = 0;
      bi = 0;
    end

  // Stop commits pending work
  always @(posedge sda)
    if (scl === 1'b1)
    begin
      if (lock_armed && !locked)
        locked <= #5000 1'b1;
      if (wrote && !wp && !locked)
        mem = shadow;
      frame_bytes = bi;
      {act, addr_ok, sda_oe} = 3'h0;
    end

  always @(posedge scl)
    if (act)
    begin
      if (cnt < 8)
        sh = {sh[6:0], sda};
      else
        mack = !sda;
      cnt++;
    end

  always @(negedge scl)
    if (act)
    begin
      if (cnt == 9)
      begin
        cnt = 0;
        sda_oe = 1'b0;
        if (rd && mack)
        begin
          ptr++;
          out = mem[ptr];
          sda_oe = !out[7];
        end
        else if (rd)
          act = 1'b0;
      end
      else if (rd)
        sda_oe = (cnt < 8) ? !out[7 - cnt] : 1'b0;
      else if (cnt == 8)
      begin
        sda_oe = accept(sh);
        bi++;
        if (slow)
        begin
          scl_oe = 1'b1;
          scl_oe <= #1000 1'b0;
        end
      end
    end
endmodule // sral_dev_model

// File: sral_host_tb.sv
// Self-checking bench for the security region host controller.
// Assumes the behavioural memory model on pulled-up wires.
`timescale 1ns/1ps
module sral_host_tb
  import sral_pkg::*;
  ;
  localparam logic [2:0] PINS = 3'h5;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid = 1'b0;
  sral_cmd_e cmd_op = OP_READ;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] cmd_count = 8'h00;
  logic [2:0] chip_select = PINS;
  logic wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic wp = 1'b0;
  logic slow = 1'b0;
  logic cmd_ready, rsp_valid, rsp_nack, rsp_refused, rd_valid, wr_ready;
  logic [7:0] rd_data;
  logic scl_oe, sda_oe, m_scl_oe, m_sda_oe, scl_w, sda_w;
  int frame_bytes, starts;
  int bad_count = 0;
  int compares = 0;
  logic [7:0] rq [$];

  assign scl_w = !(scl_oe || m_scl_oe);
  assign sda_w = !(sda_oe || m_sda_oe);

  always #5 core_clk = !core_clk;

  sral_host dut (.core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_count(cmd_count), .chip_select(chip_select), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_refused(rsp_refused), .rd_valid(rd_valid),
    .rd_data(rd_data), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .scl_sense(scl_w), .scl_val(), .scl_oe(scl_oe), .sda_sense(sda_w), .sda_val(), .sda_oe(sda_oe));

  sral_dev_model #(.PINS(PINS)) model (.scl(scl_w), .sda(sda_w), .wp(wp), .slow(slow),
    .sda_oe(m_sda_oe), .scl_oe(m_scl_oe), .frame_bytes(frame_bytes), .starts(starts));

  task automatic report_and_stop();
    if (bad_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic run(input sral_cmd_e op, input logic [7:0] a, input logic [7:0] n);
    int t;
    rq.delete();
    do @(negedge core_clk); while (cmd_ready !== 1'b1);
    cmd_op = op;
    cmd_addr = a;
    cmd_count = n;
    cmd_valid = 1'b1;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    t = 0;
    while (rsp_valid !== 1'b1 && t < 60000)
    begin
      @(negedge core_clk);
      if (rd_valid === 1'b1)
        rq.push_back(rd_data);
      t++;
    end
    chk("rsp_valid", 8'h01, {7'h00, rsp_valid});
  endtask

  task automatic push(input logic [7:0] d);
    @(negedge core_clk);
    wr_valid = 1'b1;
    wr_data = d;
    @(negedge core_clk);
    wr_valid = 1'b0;
  endtask

  task automatic t_read_serial();
    run(OP_READ, 8'h00, 8'h01);
    chk("read length", 8'h02, 8'(rq.size()));
    chk("serial byte 0", 8'h5A, rq[0]);
    chk("serial byte 1", 8'h5B, rq[1]);
    chk("read nack", 8'h00, {7'h00, rsp_nack});
  endtask

  task automatic t_write_wrap();
    push(8'h11);
    push(8'h22);
    run(OP_WRITE, 8'hFF, 8'h01);
    chk("write nack", 8'h00, {7'h00, rsp_nack});
    chk("write frame", 8'h05, 8'(frame_bytes));
    run(OP_READ, 8'hFF, 8'h01);
    chk("last byte", 8'h11, rq[0]);
    chk("wrapped byte", 8'h5A, rq[1]);
  endtask

  task automatic t_refused();
    int s;
    s = starts;
    run(OP_WRITE, 8'h10, 8'h00);
    chk("refused", 8'h01, {7'h00, rsp_refused});
    chk("no traffic", 8'(s), 8'(starts));
  endtask

  task automatic t_wp_and_cs();
    wp = 1'b1;
    push(8'h33);
    run(OP_WRITE, 8'h90, 8'h00);
    wp = 1'b0;
    run(OP_READ, 8'h90, 8'h00);
    chk("protected byte", 8'hFF, rq[0]);
    chip_select = PINS ^ 3'h1;
    run(OP_READ, 8'h00, 8'h00);
    chk("foreign select nack", 8'h01, {7'h00, rsp_nack});
    chk("foreign select data", 8'h00, 8'(rq.size()));
    chip_select = PINS;
  endtask

  task automatic t_fifo();
    int n;
    n = 0;
    for (int i = 0; i < 40; i++)
    begin
      @(negedge core_clk);
      if (wr_ready !== 1'b1)
        break;
      wr_valid = 1'b1;
      wr_data = 8'(i);
      n++;
    end
    wr_valid = 1'b0;
    chk("fifo depth", 8'h20, 8'(n));
    slow = 1'b1;
    run(OP_WRITE, 8'h80, 8'h1F);
    slow = 1'b0;
    chk("page nack", 8'h00, {7'h00, rsp_nack});
    chk("page frame", 8'h23, 8'(frame_bytes));
    chk("fifo drained", 8'h01, {7'h00, wr_ready});
    run(OP_READ, 8'h9F, 8'h00);
    chk("page tail", 8'h1F, rq[0]);
  endtask

  task automatic t_lock();
    run(OP_CHECK, 8'h00, 8'h00);
    chk("open check", 8'h00, {7'h00, rsp_nack});
    chk("check frame", 8'h02, 8'(frame_bytes));
    wp = 1'b1;
    run(OP_LOCK, 8'h00, 8'h00);
    wp = 1'b0;
    chk("lock nack", 8'h00, {7'h00, rsp_nack});
    chk("lock frame", 8'h04, 8'(frame_bytes));
    @(negedge core_clk);
    rstn = 1'b0;
    repeat (8) @(negedge core_clk);
    rstn = 1'b1;
    run(OP_CHECK, 8'h00, 8'h00);
    chk("locked check", 8'h01, {7'h00, rsp_nack});
    run(OP_LOCK, 8'h00, 8'h00);
    chk("relock nack", 8'h01, {7'h00, rsp_nack});
    push(8'h44);
    run(OP_WRITE, 8'h90, 8'h00);
    run(OP_READ, 8'h90, 8'h00);
    chk("locked byte", 8'h10, rq[0]);
  endtask

  initial
  begin
    #950000;
    bad_count++;
    report_and_stop();
  end

  initial
  begin
    repeat (8) @(negedge core_clk);
    rstn = 1'b1;
    t_read_serial();
    t_write_wrap();
    t_refused();
    t_wp_and_cs();
    t_fifo();
    t_lock();
    report_and_stop();
  end
endmodule // sral_host_tb
